// >>> src/atps_ctl.sv
// Power regulation loop with edge shaping and receiver tuning.
// Assumes a current meter answering a request, a regulator taking a
// 100 mV step index, and software loading tables over the plain port.
// Summary of operation
// R01 - Measure, compute, apply, shape, adjust receiver in order
// R02 - New voltage equals voltage over current times target
// R03 - Table row index is regulator select, zero 1.5V
// R04 - Rows step 100 mV, row 42 is 5.7V
// R05 - Byte 0 is unsigned target current reduction
// R06 - Byte 1 signed modulated amplitude change
// R07 - Byte 2 signed full-keying fall/rise edge changes
// R08 - Byte 3 signed ten-percent fall/rise edge changes
// R09 - Shaping chosen by detuning row and protocol
// R10 - Computed or table-driven shaping mechanism
// R11 - Edge style: one, two or three segments
// R12 - Style set per protocol, fall and rise
// R13 - Per protocol edge time constant and length
// R14 - Adaptation rewrites gain, detect threshold and smoothing enable
// R15 - Adaptation wins over configuration load values
// R16 - Adaptation runs only after supply voltage change
// R17 - Gain, threshold, smoothing enable copied from table
// R18 - Up to five ranges, count from config
// R19 - Ascending thresholds bound each range
// R20 - Act only when deviation exceeds hysteresis
// R21 - Enabled by 0x39, disabled by 0x00
// R22 - Separate target and maximum per mode
// R23 - Five receiver entries per protocol, range picks
// R24 - Round to nearest step, clamp to maximum
//
// The plain strobed port was chosen for this implementation.
`include "atps_params.svh"
`timescale 1ns/1ps
`default_nettype none

module atps_ctl (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_meas_req,
   input wire logic i_meas_valid,
   input wire logic [9:0] i_meas_ma,
   output logic [5:0] o_vsel,
   output logic o_vsel_load,
   output atps_pkg::atps_shape_t o_shape,
   output atps_pkg::atps_rx_t o_rx,
   output logic o_rx_upd,
   input wire logic i_rf_load,
   input wire atps_pkg::atps_rx_t i_rf_load_rx
);
   atps_pkg::atps_state_t state_r;
   logic [31:0] ctrl_r, hyst_r, tgt_r, vmax_r, rxcfg_r;
   logic [39:0] thr_r;
   logic [31:0] edge_r [4];
   logic [31:0] ptab_r [`ATPS_PTAB_N];
   logic [15:0] rxtab_r [`ATPS_RXTAB_N];
   logic [9:0] meas_r;
   logic [5:0] vnew_r;
   logic [2:0] range_r;
   logic meas_req_r;
   logic enabled;
   logic mode_nfc;
   logic [1:0] proto;
   logic [9:0] tgt_base, tgt_eff;
   logic [5:0] vmax_eff;
   logic [31:0] entry;
   logic [10:0] diff;
   logic in_hyst;
   logic [15:0] prod;
   logic [16:0] quot;
   logic [5:0] vcalc;
   logic [2:0] range_nxt;
   logic [4:0] rx_idx;
   logic [15:0] rx_word;
   logic [31:0] edge_cfg;

   function automatic logic [3:0] sat4(input logic [3:0] b,
                                       input logic [3:0] d);
      logic [5:0] s;
      s = {2'h0, b} + {{2{d[3]}}, d};
      if (s[5]) begin
         sat4 = 4'h0;
      end else if (s[4]) begin
         sat4 = 4'hf;
      end else begin
         sat4 = s[3:0];
      end
   endfunction

   function automatic logic [7:0] sat8(input logic [7:0] b,
                                       input logic [7:0] d);
      logic [9:0] s;
      s = {2'h0, b} + {{2{d[7]}}, d};
      if (s[9]) begin
         sat8 = 8'h00;
      end else if (s[8]) begin
         sat8 = 8'hff;
      end else begin
         sat8 = s[7:0];
      end
   endfunction

   // Range index is the count of passed thresholds among active ones
   function automatic logic [2:0] range_of(input logic [5:0] v,
                                           input logic [39:0] thr,
                                           input logic [2:0] n);
      logic [2:0] cnt;
      logic [2:0] lim;
      cnt = 3'h0;
      lim = (n > `ATPS_RANGES) ? `ATPS_RANGES : n;
      for (int k = 0; k < 4; k++) begin
         if (3'(k + 1) < lim && {2'h0, v} >= thr[k*8 +: 8]) begin
            cnt = cnt + 3'h1;
         end
      end
      range_of = cnt;
   endfunction

   assign enabled = ctrl_r[7:0] == `ATPS_EN_VAL; // R21
   assign mode_nfc = ctrl_r[8];
   assign proto = ctrl_r[10:9];
   assign tgt_base = mode_nfc ? tgt_r[25:16] : tgt_r[9:0]; // R22
   assign vmax_eff = mode_nfc ? vmax_r[13:8] : vmax_r[5:0]; // R22
   assign entry = ptab_r[o_vsel]; // R03
   assign edge_cfg = edge_r[proto];

   // Reduction floors at zero rather than wrapping the target
   assign tgt_eff = (tgt_base > {2'h0, entry[7:0]}) ?
                    tgt_base - {2'h0, entry[7:0]} : 10'h000; // R05
   assign diff = (meas_r > tgt_eff) ? {1'b0, meas_r - tgt_eff} :
                 {1'b0, tgt_eff - meas_r};
   assign in_hyst = diff <= {3'h0, hyst_r[7:0]}; // R20

   // Voltage in 100 mV units is row plus 15, row 0 at 1.5 V
   assign prod = 16'({10'h000, o_vsel + `ATPS_VOFS} * tgt_eff); // R02 R04
   assign quot = (meas_r == 10'h000) ? 17'h1ffff :
                 ({1'b0, prod} + {8'h00, meas_r[9:1]}) /
                 {7'h00, meas_r}; // R24

   always_comb begin
      if (quot <= {11'h000, `ATPS_VOFS}) begin
         vcalc = 6'h00;
      end else if (quot - {11'h000, `ATPS_VOFS} >= {11'h000, vmax_eff}) begin
         vcalc = vmax_eff;
      end else begin
         vcalc = 6'(quot - {11'h000, `ATPS_VOFS});
      end
      if (vcalc > `ATPS_VIDX_MAX) begin
         vcalc = `ATPS_VIDX_MAX; // R24
      end
   end

   assign range_nxt = range_of(vnew_r, thr_r, rxcfg_r[2:0]); // R18 R19
   assign rx_idx = 5'({3'h0, proto} * 5'(`ATPS_RX_PER_PROTO)) +
                   {2'h0, range_r}; // R23
   assign rx_word = rxtab_r[rx_idx];

   // Regulation sequencer
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_r <= atps_pkg::ST_IDLE;
      end else begin
         case (state_r)
            atps_pkg::ST_IDLE: begin
               if (enabled) begin
                  state_r <= atps_pkg::ST_MEAS; // R01 R21
               end
            end
            atps_pkg::ST_MEAS: begin
               if (i_meas_valid) begin
                  state_r <= atps_pkg::ST_CALC; // R01
               end
            end
            atps_pkg::ST_CALC: begin
               if (in_hyst) begin
                  state_r <= atps_pkg::ST_IDLE; // R20
               end else begin
                  state_r <= atps_pkg::ST_APPLY; // R01
               end
            end
            atps_pkg::ST_APPLY: state_r <= atps_pkg::ST_SHAPE; // R01
            atps_pkg::ST_SHAPE: begin
               if (vnew_r != o_vsel || o_vsel_load) begin
                  state_r <= atps_pkg::ST_RXADJ; // R16
               end else begin
                  state_r <= atps_pkg::ST_IDLE;
               end
            end
            atps_pkg::ST_RXADJ: state_r <= atps_pkg::ST_IDLE; // R01
            default: state_r <= atps_pkg::ST_IDLE;
         endcase
      end
   end

   // Measurement request, one pulse per loop pass
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         meas_req_r <= 1'b0;
         meas_r <= 10'h000;
      end else begin
         meas_req_r <= state_r == atps_pkg::ST_IDLE && enabled;
         if (state_r == atps_pkg::ST_MEAS && i_meas_valid) begin
            meas_r <= i_meas_ma;
         end
      end
   end
   assign o_meas_req = meas_req_r;

   // Voltage computation and regulator update
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         vnew_r <= 6'h00;
         o_vsel <= 6'h00;
         o_vsel_load <= 1'b0;
         range_r <= 3'h0;
      end else begin
         o_vsel_load <= 1'b0;
         if (state_r == atps_pkg::ST_CALC) begin
            vnew_r <= vcalc; // R02 R24
         end
         if (state_r == atps_pkg::ST_APPLY) begin
            o_vsel <= vnew_r; // R03
            o_vsel_load <= vnew_r != o_vsel;
            range_r <= range_nxt; // R18
         end
      end
   end

   // Shaping outputs follow the new row and active protocol
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_shape <= '0;
      end else if (state_r == atps_pkg::ST_SHAPE) begin // R09
         o_shape.table_mech <= ctrl_r[11]; // R10
         o_shape.fall_style <= edge_cfg[1:0]; // R11 R12
         o_shape.rise_style <= edge_cfg[3:2]; // R12
         o_shape.edge_len <= edge_cfg[19:12]; // R13
         o_shape.amp_mod <= sat8(edge_cfg[27:20], entry[15:8]); // R06
         if (edge_cfg[28]) begin
            o_shape.fall_tc <= sat4(edge_cfg[7:4], entry[27:24]); // R08
            o_shape.rise_tc <= sat4(edge_cfg[11:8], entry[31:28]); // R08
         end else begin
            o_shape.fall_tc <= sat4(edge_cfg[7:4], entry[19:16]); // R07
            o_shape.rise_tc <= sat4(edge_cfg[11:8], entry[23:20]); // R07
         end
      end
   end

   // Receiver registers; adaptation beats a same-cycle config load
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_rx <= '0;
         o_rx_upd <= 1'b0;
      end else begin
         o_rx_upd <= state_r == atps_pkg::ST_RXADJ;
         if (state_r == atps_pkg::ST_RXADJ) begin
            o_rx.mf_gain <= rx_word[8:7]; // R14 R15 R17
            o_rx.sd_thr <= rx_word[6:0]; // R14 R15 R17
            o_rx.smooth_en <= rx_word[9]; // R17
         end else if (i_rf_load) begin
            o_rx <= i_rf_load_rx;
         end else if (i_wr && i_addr == `ATPS_A_MF_TECH) begin
            o_rx.mf_gain <= i_wdata[1:0];
            o_rx.smooth_en <= i_wdata[2];
         end else if (i_wr && i_addr == `ATPS_A_SD_THR) begin
            o_rx.sd_thr <= i_wdata[6:0];
         end
      end
   end

   // Configuration registers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ctrl_r <= `ATPS_RST_CTRL;
         hyst_r <= `ATPS_RST_HYST;
         tgt_r <= `ATPS_RST_TGT;
         vmax_r <= `ATPS_RST_VMAX;
         rxcfg_r <= 32'h0000_0005;
         thr_r <= 40'h00_0000_0000;
      end else if (i_wr) begin
         case (i_addr)
            `ATPS_A_CTRL: ctrl_r <= {20'h00000, i_wdata[11:0]};
            `ATPS_A_HYST: hyst_r <= {24'h000000, i_wdata[7:0]};
            `ATPS_A_TGT: tgt_r <= i_wdata & 32'h03ff_03ff;
            `ATPS_A_VMAX: vmax_r <= i_wdata & 32'h0000_3f3f;
            `ATPS_A_RXCFG: rxcfg_r <= {29'h0, i_wdata[2:0]};
            `ATPS_A_THR_LO: thr_r[31:0] <= i_wdata;
            `ATPS_A_THR_HI: thr_r[39:32] <= i_wdata[7:0];
            default: ;
         endcase
      end
   end

   // Tables are plain storage written only by software
   always_ff @(posedge i_clk) begin
      if (i_wr && i_addr >= `ATPS_A_PTAB && i_addr <= `ATPS_A_PTAB_END) begin
         ptab_r[6'(i_addr - `ATPS_A_PTAB)] <= i_wdata;
      end
      if (i_wr && i_addr >= `ATPS_A_RXTAB &&
          i_addr <= `ATPS_A_RXTAB_END) begin
         rxtab_r[5'(i_addr - `ATPS_A_RXTAB)] <= i_wdata[15:0];
      end
      if (i_wr && i_addr >= `ATPS_A_EDGE && i_addr <= `ATPS_A_EDGE_END) begin
         edge_r[i_addr[1:0]] <= {3'h0, i_wdata[28:0]};
      end
   end

   // Read port, data one cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         if (i_addr >= `ATPS_A_PTAB && i_addr <= `ATPS_A_PTAB_END) begin
            o_rdata <= ptab_r[6'(i_addr - `ATPS_A_PTAB)];
         end else if (i_addr >= `ATPS_A_RXTAB &&
                      i_addr <= `ATPS_A_RXTAB_END) begin
            o_rdata <= {16'h0000, rxtab_r[5'(i_addr - `ATPS_A_RXTAB)]};
         end else if (i_addr >= `ATPS_A_EDGE &&
                      i_addr <= `ATPS_A_EDGE_END) begin
            o_rdata <= edge_r[i_addr[1:0]];
         end else begin
            case (i_addr)
               `ATPS_A_CTRL: o_rdata <= ctrl_r;
               `ATPS_A_HYST: o_rdata <= hyst_r;
               `ATPS_A_TGT: o_rdata <= tgt_r;
               `ATPS_A_VMAX: o_rdata <= vmax_r;
               `ATPS_A_RXCFG: o_rdata <= rxcfg_r;
               `ATPS_A_THR_LO: o_rdata <= thr_r[31:0];
               `ATPS_A_THR_HI: o_rdata <= {24'h000000, thr_r[39:32]};
               `ATPS_A_STATUS: o_rdata <= {16'h0000, 2'h0, state_r,
                                           range_r, 2'h0, o_vsel};
               `ATPS_A_MEAS: o_rdata <= {22'h000000, meas_r};
               `ATPS_A_MF_TECH: o_rdata <= {29'h0, o_rx.smooth_en,
                                            o_rx.mf_gain};
               `ATPS_A_SD_THR: o_rdata <= {25'h0, o_rx.sd_thr};
               default: o_rdata <= 32'h0000_0000;
            endcase
         end
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   property p_meas_to_calc;
      @(posedge i_clk) disable iff (i_srst)
      (state_r == atps_pkg::ST_MEAS && i_meas_valid) |=>
         state_r == atps_pkg::ST_CALC ##1
         state_r inside {atps_pkg::ST_IDLE, atps_pkg::ST_APPLY};
   endproperty
   a_meas_to_calc: assert property (p_meas_to_calc) // R01
      else $error("Loop did not go from measure to compute");

   property p_order;
      @(posedge i_clk) disable iff (i_srst)
      state_r == atps_pkg::ST_APPLY |=> state_r == atps_pkg::ST_SHAPE;
   endproperty
   a_order: assert property (p_order) // R01
      else $error("Apply was not followed by shaping");

   property p_hyst;
      @(posedge i_clk) disable iff (i_srst)
      (state_r == atps_pkg::ST_CALC && in_hyst) |=>
         state_r == atps_pkg::ST_IDLE && $stable(o_vsel);
   endproperty
   a_hyst: assert property (p_hyst) // R20
      else $error("Loop acted inside the hysteresis band");

   property p_clamp;
      @(posedge i_clk) disable iff (i_srst)
      o_vsel_load |-> o_vsel <= $past(vmax_eff, 2) &&
         o_vsel <= `ATPS_VIDX_MAX;
   endproperty
   a_clamp: assert property (p_clamp) // R24
      else $error("Applied supply step above the maximum");

   property p_load;
      @(posedge i_clk) disable iff (i_srst)
      (state_r == atps_pkg::ST_APPLY && vnew_r != o_vsel) |=>
         o_vsel_load && o_vsel == $past(vnew_r);
   endproperty
   a_load: assert property (p_load) // R03
      else $error("Regulator not loaded with the new step");

   property p_rx_only_on_change;
      @(posedge i_clk) disable iff (i_srst)
      o_rx_upd |-> $past(state_r, 2) == atps_pkg::ST_SHAPE;
   endproperty
   a_rx_only_on_change: assert property (p_rx_only_on_change) // R16
      else $error("Receiver adjusted outside the loop sequence");

   property p_rx_copy;
      @(posedge i_clk) disable iff (i_srst)
      state_r == atps_pkg::ST_RXADJ |=>
         o_rx.mf_gain == $past(rx_word[8:7]) &&
         o_rx.sd_thr == $past(rx_word[6:0]) &&
         o_rx.smooth_en == $past(rx_word[9]);
   endproperty
   a_rx_copy: assert property (p_rx_copy) // R17
      else $error("Receiver settings differ from table entry");

   property p_prec;
      @(posedge i_clk) disable iff (i_srst)
      (state_r == atps_pkg::ST_RXADJ && i_rf_load) |=>
         o_rx.sd_thr == $past(rx_word[6:0]);
   endproperty
   a_prec: assert property (p_prec) // R15
      else $error("Config load overrode receiver adaptation");

   property p_range;
      @(posedge i_clk) disable iff (i_srst)
      range_r <= 3'h4;
   endproperty
   a_range: assert property (p_range) // R18
      else $error("Supply range index above four");

   property p_disabled;
      @(posedge i_clk) disable iff (i_srst)
      (state_r == atps_pkg::ST_IDLE && !enabled) |=>
         state_r == atps_pkg::ST_IDLE;
   endproperty
   a_disabled: assert property (p_disabled) // R21
      else $error("Loop ran while disabled");
endmodule

`default_nettype wire

// >>> src/atps_params.svh
// Constants of the adaptive transmit power and shaping controller.
// Assumes word addressing on the plain register port.
`ifndef ATPS_PARAMS_SVH
`define ATPS_PARAMS_SVH

`define ATPS_A_CTRL 8'h00
`define ATPS_A_HYST 8'h01
`define ATPS_A_TGT 8'h02
`define ATPS_A_VMAX 8'h03
`define ATPS_A_RXCFG 8'h04
`define ATPS_A_THR_LO 8'h05
`define ATPS_A_THR_HI 8'h06
`define ATPS_A_STATUS 8'h07
`define ATPS_A_MEAS 8'h08
`define ATPS_A_EDGE 8'h10
`define ATPS_A_EDGE_END 8'h13
`define ATPS_A_MF_TECH 8'h22
`define ATPS_A_SD_THR 8'h30
`define ATPS_A_PTAB 8'h40
`define ATPS_A_PTAB_END 8'h6a
`define ATPS_A_RXTAB 8'h80
`define ATPS_A_RXTAB_END 8'h93

`define ATPS_EN_VAL 8'h39
`define ATPS_DIS_VAL 8'h00
`define ATPS_PTAB_N 43
`define ATPS_RXTAB_N 20
`define ATPS_RX_PER_PROTO 5
`define ATPS_VIDX_MAX 6'h2a
`define ATPS_VOFS 6'h0f
`define ATPS_RANGES 3'h5
`define ATPS_RST_VMAX 32'h0000_2a2a
`define ATPS_RST_TGT 32'h0118_0118
`define ATPS_RST_HYST 32'h0000_0014
`define ATPS_RST_CTRL 32'h0000_0000

`endif

// >>> src/atps_pkg.sv
// Types of the adaptive transmit power and shaping controller.
// Assumes atps_params.svh supplies the numeric constants.
package atps_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_MEAS = 3'b001,
      ST_CALC = 3'b010,
      ST_APPLY = 3'b011,
      ST_SHAPE = 3'b100,
      ST_RXADJ = 3'b101
   } atps_state_t;

   typedef struct packed {
      logic table_mech;
      logic [1:0] fall_style;
      logic [1:0] rise_style;
      logic [3:0] fall_tc;
      logic [3:0] rise_tc;
      logic [7:0] edge_len;
      logic [7:0] amp_mod;
   } atps_shape_t;

   typedef struct packed {
      logic [1:0] mf_gain;
      logic [6:0] sd_thr;
      logic smooth_en;
   } atps_rx_t;
endpackage

// >>> tb/atps_fe_model.sv
// Model of the supply regulator and current meter beside the controller.
// Assumes the controller raises a measurement request once per pass.
`timescale 1ns/1ps
`default_nettype none

module atps_fe_model (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_meas_req,
   input wire logic [5:0] i_vsel,
   input wire logic [15:0] i_g,
   input wire logic [3:0] i_lag,
   output logic o_meas_valid,
   output logic [9:0] o_meas_ma
);
   logic req_q_r;
   logic busy_r;
   logic [3:0] cnt_r;
   logic [9:0] last_r;
   logic [31:0] cur;

   // Load current follows the applied supply step
   assign cur = ((32'(i_vsel) + 32'd15) * 32'(i_g)) / 32'd64;

   always_ff @(posedge i_clk) begin
      req_q_r <= i_meas_req;
      o_meas_valid <= 1'b0;
      // Meter output is meaningless outside the answer cycle
      o_meas_ma <= ~last_r;
      if (i_srst) begin
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         last_r <= 10'h000;
      end else if (!busy_r && i_meas_req && !req_q_r) begin
         busy_r <= 1'b1;
         cnt_r <= i_lag;
      end else if (busy_r && cnt_r == 4'h0) begin
         busy_r <= 1'b0;
         o_meas_valid <= 1'b1;
         o_meas_ma <= (cur > 32'd1023) ? 10'h3ff : cur[9:0];
         last_r <= (cur > 32'd1023) ? 10'h3ff : cur[9:0];
      end else if (busy_r) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule

`default_nettype wire

// >>> tb/atps_ctl_tb.sv
// Self-checking bench of the power regulation and tuning controller.
// Assumes the regulator model answers measurement requests.
`include "atps_params.svh"
`timescale 1ns/1ps
`default_nettype none

module atps_ctl_tb;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [7:0] i_addr;
   logic [31:0] i_wdata;
   logic i_wr;
   logic i_rd;
   logic [31:0] o_rdata;
   logic o_meas_req;
   logic meas_valid;
   logic [9:0] meas_ma;
   logic [5:0] o_vsel;
   logic o_vsel_load;
   atps_pkg::atps_shape_t o_shape;
   atps_pkg::atps_rx_t o_rx;
   logic o_rx_upd;
   logic i_rf_load;
   atps_pkg::atps_rx_t i_rf_load_rx;
   logic [15:0] g;
   logic [3:0] lag;
   int err_total = 0;
   int comparisons = 0;
   logic [7:0] ra [6] = '{`ATPS_A_CTRL, `ATPS_A_HYST, `ATPS_A_TGT,
      `ATPS_A_VMAX, `ATPS_A_RXCFG, 8'h7f};
   logic [31:0] rv [6] = '{`ATPS_RST_CTRL, `ATPS_RST_HYST, `ATPS_RST_TGT,
      `ATPS_RST_VMAX, 32'h0000_0005, 32'h0000_0000};

   always #5 i_clk = ~i_clk;

   atps_ctl i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_meas_req(o_meas_req), .i_meas_valid(meas_valid),
      .i_meas_ma(meas_ma), .o_vsel(o_vsel), .o_vsel_load(o_vsel_load),
      .o_shape(o_shape), .o_rx(o_rx), .o_rx_upd(o_rx_upd),
      .i_rf_load(i_rf_load), .i_rf_load_rx(i_rf_load_rx));

   atps_fe_model i_fe (.i_clk(i_clk), .i_srst(i_srst),
      .i_meas_req(o_meas_req), .i_vsel(o_vsel), .i_g(g), .i_lag(lag),
      .o_meas_valid(meas_valid), .o_meas_ma(meas_ma));

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m, input string nm);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      check(nm, e, o_rdata & m);
   endtask

   // Mirror of the meter plus rounding and clamping of the new step
   function automatic logic [5:0] nrow(int row, int gg, int t, int vmax);
      int v;
      int ima;
      int n;
      v = row + 15;
      ima = (v * gg) / 64;
      n = (2 * v * t + ima) / (2 * ima) - 15;
      if (n < 0) n = 0;
      if (n > vmax) n = vmax;
      return 6'(n);
   endfunction

   // Receiver table entry n and the outputs it must produce
   function automatic logic [31:0] rxent(int n);
      return {22'h0, 1'(n), 2'(n), 7'(n + 32)};
   endfunction

   function automatic logic [9:0] rxe(int n);
      return {2'(n), 7'(n + 32), 1'(n)};
   endfunction

   function automatic logic [28:0] shp(int amp, int ftc, int rtc);
      return {1'b0, 2'h1, 2'h2, 4'(ftc), 4'(rtc), 8'h40, 8'(amp)};
   endfunction

   task automatic wait_step(input logic [5:0] ev, input logic [9:0] erx,
      input logic chk_sh, input logic [28:0] esh);
      int k;
      k = 0;
      tick(1);
      while (o_vsel_load !== 1'b1 && k < 400) begin
         tick(1);
         k++;
      end
      if (k == 400) begin
         err_total++;
         final_report();
      end
      check("vsel", 32'(ev), 32'(o_vsel));
      tick(1);
      if (chk_sh) check("shape", 32'(esh), 32'(o_shape));
      tick(1);
      check("rx_upd", 32'h1, 32'(o_rx_upd));
      check("rx", 32'(erx), 32'(o_rx));
   endtask

   // Counts step loads, adaptations and optionally requests
   task automatic quiet(input int n, input logic with_req, input string nm);
      int c;
      c = 0;
      repeat (n) begin
         tick(1);
         c += int'(o_vsel_load !== 1'b0) + int'(o_rx_upd !== 1'b0);
         if (with_req) c += int'(o_meas_req !== 1'b0);
      end
      check(nm, 32'h0, 32'(c));
   endtask

   initial begin
      i_addr = 8'h00;
      i_wdata = 32'h0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_rf_load = 1'b0;
      i_rf_load_rx = atps_pkg::atps_rx_t'(10'h000);
      g = 16'd390;
      lag = 4'h2;
      repeat (5) @(posedge i_clk);
      i_srst <= 1'b0;
      tick(1);
      check("outs", 32'h0, 32'({o_vsel, o_rx, o_meas_req, o_vsel_load}));
      check("shape rst", 32'h0, 32'(o_shape));
      for (int i = 0; i < 6; i++) rd(ra[i], rv[i], 32'hffff_ffff, "reg");
      quiet(40, 1'b1, "idle off");
      for (int i = 0; i < `ATPS_PTAB_N; i++) wr(`ATPS_A_PTAB + 8'(i), 0);
      for (int i = 0; i < `ATPS_RXTAB_N; i++) begin
         wr(`ATPS_A_RXTAB + 8'(i), rxent(i));
      end
      // Row 31: amp +5, full-keying fall -1 rise -3
      wr(`ATPS_A_PTAB + 8'd31, 32'h11df_0500);
      for (int p = 0; p < 4; p++) wr(`ATPS_A_EDGE + 8'(p), 32'h0c84_0339);
      wr(`ATPS_A_THR_LO, 32'h281e_140a);
      wr(`ATPS_A_THR_HI, 32'h0000_0032);
      wr(`ATPS_A_CTRL, 32'(`ATPS_EN_VAL));
      wait_step(nrow(42, 390, 280, 42), rxe(3), 1'b1, shp(205, 2, 0));
      rd(`ATPS_A_MF_TECH, 32'h7, 32'h7, "mf tech");
      rd(`ATPS_A_SD_THR, 32'h23, 32'h7f, "sd thr");
      quiet(60, 1'b0, "settled");
      // Reduction of 40 mA on rows 24 and 31
      // Row 24 first, so the step cannot fire before wait_step looks
      wr(`ATPS_A_PTAB + 8'd24, 32'h0000_0028);
      wr(`ATPS_A_PTAB + 8'd31, 32'h11df_0528);
      wait_step(nrow(31, 390, 240, 42), rxe(2), 1'b1, shp(200, 3, 3));
      quiet(60, 1'b0, "settled low");
      @(posedge i_clk);
      i_rf_load <= 1'b1;
      i_rf_load_rx <= atps_pkg::atps_rx_t'(10'h2a5);
      @(posedge i_clk);
      #1;
      check("rf load", 32'h2a5, 32'(o_rx));
      // Config load held across the adaptation, which must still win
      lag <= 4'h9;
      g <= 16'd100;
      wait_step(nrow(24, 100, 240, 42), rxe(4), 1'b1, shp(200, 3, 3));
      @(posedge i_clk);
      i_rf_load <= 1'b0;
      wr(`ATPS_A_RXCFG, 32'h2);
      wr(`ATPS_A_VMAX, 32'h0000_232a);
      // Protocol 1 uses ten-percent keying; row 35 fall +1 rise +2
      wr(`ATPS_A_EDGE + 8'd1, 32'h1c84_0339);
      wr(`ATPS_A_PTAB + 8'd35, 32'h2100_0000);
      wr(`ATPS_A_CTRL, 32'h0000_0b39);
      wait_step(nrow(42, 100, 280, 35), rxe(6), 1'b1,
         shp(200, 4, 5) | 29'h1000_0000);
      wr(`ATPS_A_CTRL, 32'(`ATPS_DIS_VAL));
      tick(20);
      quiet(60, 1'b1, "stopped");
      rd(8'h7f, 32'h0, 32'hffff_ffff, "unmapped");
      final_report();
   end
endmodule

`default_nettype wire
